//--- design/srs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module srs_sequencer
  import srs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [srs_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [srs_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [srs_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic psel_i,
  input wire logic data_io_pin_i,
  input wire logic adc_clk_i,
  input wire logic filter_clk_i,
  input wire logic [srs_pkg::NUM_SUB-1:0] subblock_clk_run_i,
  input wire logic pll_lock_i,
  input wire logic carrier_sense_i,
  input wire logic pll_cal_done_i,
  output logic [srs_pkg::NUM_SUB-1:0] subblock_rst_n_o,
  output logic synth_pu_o,
  output logic rx_pu_o,
  output logic pll_cal_o,
  output logic powered_down_o,
  output logic [7:0] freq_word_set_a_o
);

  import srs_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic wait_r;
  logic [DATA_W-1:0] rdata_r;
  logic [7:0] main_r;
  logic [7:0] iface_r;
  logic [7:0] reset_ctrl_r;
  logic [7:0] seq_cfg_r;
  logic [7:0] freq2a_r;
  logic [NUM_SUB-1:0] rst_done_w;
  logic psel_q_r;
  logic dio_q_r;
  logic adc_q_r;
  logic flt_q_r;
  srs_state_t state_r;
  srs_state_t state_nxt;
  logic [WAIT_W-1:0] wait_cnt_r;
  logic [WAIT_W-1:0] wait_cnt_nxt;
  logic [7:0] seq_cnt_r;
  logic [7:0] seq_cnt_nxt;
  logic synth_pu_r;
  logic rx_pu_r;
  logic pll_cal_r;
  logic pdown_r;

  // ---------------------------------------------------------------
  // Avalon-MM slave decode
  // ---------------------------------------------------------------
  // One wait state: the request is decoded while waitrequest is high,
  // and taken on the edge where it is low
  wire req_w = avs_read_i | avs_write_i;
  wire wait_nxt = ~(req_w & wait_r);
  wire commit_w = avs_write_i & ~wait_r & avs_byteenable_i[0];
  wire [IDX_W-1:0] idx_w = avs_address_i[ADDR_W-1:2];
  wire [7:0] wdata_w = avs_writedata_i[7:0];
  wire wr_main_w = commit_w & (idx_w == IDX_MAIN);
  wire wr_iface_w = commit_w & (idx_w == IDX_IFACE);
  wire wr_reset_w = commit_w & (idx_w == IDX_RESET);
  wire wr_seq_w = commit_w & (idx_w == IDX_SEQ);
  wire wr_freq_w = commit_w & (idx_w == IDX_FREQ2A);

  wire [7:0] rd_byte_w =
    (idx_w == IDX_MAIN) ? main_r :
    (idx_w == IDX_IFACE) ? iface_r :
    (idx_w == IDX_RESET) ? reset_ctrl_r :
    (idx_w == IDX_SEQ) ? seq_cfg_r :
    (idx_w == IDX_FREQ2A) ? freq2a_r :
    (idx_w == IDX_RST_DONE) ? rst_done_w :
    (idx_w == IDX_STATE) ? {5'h00, state_r} :
    (idx_w == IDX_SEQ_CNT) ? seq_cnt_r : 8'h00;

  wire [DATA_W-1:0] rd_word_w = {24'h000000, rd_byte_w};

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_r <= 1'b1;
      rdata_r <= '0;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= (avs_read_i & wait_r) ? rd_word_w : rdata_r;
    end
  end

  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o = rdata_r;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  wire dir_rx_w = ~main_r[MAIN_DIR_BIT];
  wire [1:0] pdm_w = main_r[MAIN_PDM_LSB +: 2];
  wire [1:0] cal_pol_w = main_r[MAIN_CAL_LSB +: 2];
  wire split_dio_w = iface_r[IFACE_SPLIT_BIT];
  wire cs_start_en_w = seq_cfg_r[CHIPSEL_START_ENABLE_BIT];
  wire [2:0] rx_wait_code_w = seq_cfg_r[SEQ_RXW_LSB +: 3];
  wire [3:0] cs_wait_code_w = seq_cfg_r[SEQ_CSW_LSB +: 4];
  wire pd_rise_w = wr_main_w & wdata_w[MAIN_SPD_BIT] & ~main_r[MAIN_SPD_BIT];

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      main_r <= MAIN_RST;
      iface_r <= IFACE_RST;
      seq_cfg_r <= SEQ_CFG_RST;
      freq2a_r <= FREQ2A_RST;
    end else begin
      main_r <= wr_main_w ? wdata_w : main_r;
      iface_r <= wr_iface_w ? wdata_w : iface_r;
      seq_cfg_r <= wr_seq_w ? wdata_w : seq_cfg_r;
      freq2a_r <= wr_freq_w ? wdata_w : freq2a_r;
    end
  end

  assign freq_word_set_a_o = freq2a_r;

  // ---------------------------------------------------------------
  // Sub-block resets
  // ---------------------------------------------------------------
  // A zero written starts that reset; the register refills with ones
  // on the next edge, so each start is a single-cycle pulse
  wire [NUM_SUB-1:0] rst_start_w = ~reset_ctrl_r;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_ctrl_r <= RESET_CTRL_RST;
    end else begin
      reset_ctrl_r <= wr_reset_w ? wdata_w : 8'hff;
    end
  end

  // Bit three drives one line shared by modulator, bit sync and PRBS
  for (genvar g = 0; g < NUM_SUB; g++) begin : g_sub
    srs_subrst #(
      .HOLD_CYCLES(SUBRST_CYCLES)
    ) u_subrst (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .start_i(rst_start_w[g]),
      .clk_run_i(subblock_clk_run_i[g]),
      .rst_n_o(subblock_rst_n_o[g]),
      .done_o(rst_done_w[g])
    );
  end

  // ---------------------------------------------------------------
  // Trigger and clock edge detection
  // ---------------------------------------------------------------
  // The analog-side clocks are sampled, so they must run below half
  // the system clock rate
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      psel_q_r <= 1'b1;
      dio_q_r <= 1'b1;
      adc_q_r <= 1'b0;
      flt_q_r <= 1'b0;
    end else begin
      psel_q_r <= psel_i;
      dio_q_r <= data_io_pin_i;
      adc_q_r <= adc_clk_i;
      flt_q_r <= filter_clk_i;
    end
  end

  wire psel_fall_w = psel_q_r & ~psel_i;
  wire dio_fall_w = dio_q_r & ~data_io_pin_i;
  wire adc_edge_w = adc_clk_i & ~adc_q_r;
  wire flt_edge_w = filter_clk_i & ~flt_q_r;
  wire seq_en_w = (pdm_w == PDM_SEQUENCED) & dir_rx_w;
  wire trig_w = seq_en_w & (cs_start_en_w ? psel_fall_w :
                            (split_dio_w & dio_fall_w));

  // ---------------------------------------------------------------
  // Power-up sequence
  // ---------------------------------------------------------------
  wire [WAIT_W-1:0] rx_target_w = RX_WAIT_TAB[rx_wait_code_w];
  wire [WAIT_W-1:0] cs_target_w = CS_WAIT_TAB[cs_wait_code_w];
  wire [WAIT_W-1:0] cnt_inc_w = wait_cnt_r + 1'b1;
  wire rx_wait_end_w = (rx_target_w == '0) | (adc_edge_w & (cnt_inc_w >= rx_target_w));
  wire cs_wait_end_w = flt_edge_w & (cnt_inc_w >= cs_target_w);
  wire cal_due_w = (cal_pol_w == CAL_ALWAYS) |
                   ((cal_pol_w == CAL_EVERY16) & (seq_cnt_r[3:0] == 4'hf)) |
                   ((cal_pol_w == CAL_EVERY256) & (seq_cnt_r == 8'hff));
  wire seq_held_w = ~subblock_rst_n_o[SUB_SEQ_IDX];

  always_comb begin
    state_nxt = state_r;
    wait_cnt_nxt = wait_cnt_r;
    seq_cnt_nxt = seq_cnt_r;
    unique case (state_r)
      SRS_PDOWN: begin
        wait_cnt_nxt = '0;
        if (trig_w) begin
          state_nxt = SRS_SYNTH_UP;
        end
      end
      SRS_SYNTH_UP: begin
        if (pll_lock_i) begin
          state_nxt = SRS_RX_DELAY;
        end
      end
      SRS_RX_DELAY: begin
        if (rx_wait_end_w) begin
          state_nxt = SRS_RX_ON;
          wait_cnt_nxt = '0;
        end else if (adc_edge_w) begin
          wait_cnt_nxt = cnt_inc_w;
        end
      end
      SRS_RX_ON: begin
        if (carrier_sense_i) begin
          state_nxt = SRS_RX_ACTIVE;
        end else if (cs_wait_end_w) begin
          state_nxt = cal_due_w ? SRS_CAL : SRS_PDOWN;
          seq_cnt_nxt = seq_cnt_r + 1'b1;
        end else if (flt_edge_w) begin
          wait_cnt_nxt = cnt_inc_w;
        end
      end
      SRS_RX_ACTIVE: begin
        state_nxt = SRS_RX_ACTIVE;
      end
      SRS_CAL: begin
        if (pll_cal_done_i) begin
          state_nxt = SRS_PDOWN;
        end
      end
      default: begin
        state_nxt = SRS_PDOWN;
      end
    endcase
    if (pd_rise_w || seq_held_w) begin
      state_nxt = SRS_PDOWN;
    end
  end

  wire synth_nxt_w = (state_nxt != SRS_PDOWN);
  wire rx_nxt_w = (state_nxt == SRS_RX_ON) | (state_nxt == SRS_RX_ACTIVE);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= SRS_PDOWN;
      wait_cnt_r <= '0;
      seq_cnt_r <= 8'h00;
      synth_pu_r <= 1'b0;
      rx_pu_r <= 1'b0;
      pll_cal_r <= 1'b0;
      pdown_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      seq_cnt_r <= seq_cnt_nxt;
      synth_pu_r <= synth_nxt_w;
      rx_pu_r <= rx_nxt_w;
      pll_cal_r <= (state_nxt == SRS_CAL);
      pdown_r <= ~synth_nxt_w;
    end
  end

  assign synth_pu_o = synth_pu_r;
  assign rx_pu_o = rx_pu_r;
  assign pll_cal_o = pll_cal_r;
  assign powered_down_o = pdown_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  a_reset_self_clear: assert property (
    reset_ctrl_r != 8'hff && !wr_reset_w |=> reset_ctrl_r == 8'hff)
    else $error("reset register bits did not return to one");

  a_psel_start: assert property (
    state_r == SRS_PDOWN && seq_en_w && cs_start_en_w && psel_fall_w
    && !pd_rise_w && !seq_held_w |=> synth_pu_o && state_r == SRS_SYNTH_UP)
    else $error("chip-select fall did not start a sequence");

  a_dio_gate: assert property (
    state_r == SRS_PDOWN && !cs_start_en_w && !(split_dio_w && dio_fall_w)
    |=> state_r == SRS_PDOWN)
    else $error("sequence started without a data pin trigger");

  a_rx_delay_len: assert property (
    state_r == SRS_RX_DELAY && state_nxt == SRS_RX_ON && !pd_rise_w && !seq_held_w
    |-> rx_target_w == '0 || wait_cnt_r + 1'b1 == rx_target_w)
    else $error("receiver powered before its delay");

  a_cs_wait_len: assert property (
    state_r == SRS_RX_ON && !carrier_sense_i && state_nxt != SRS_RX_ON
    && !pd_rise_w && !seq_held_w |-> wait_cnt_r + 1'b1 == cs_target_w)
    else $error("carrier wait ended at the wrong count");

  a_freq_hold: assert property (
    !wr_freq_w |=> $stable(freq_word_set_a_o))
    else $error("frequency word changed without a write");

  a_mode_gate: assert property (
    state_r == SRS_PDOWN && !seq_en_w |=> state_r == SRS_PDOWN && !synth_pu_o)
    else $error("sequence ran outside receive sequencing mode");

  a_pd_abort: assert property (
    pd_rise_w |=> state_r == SRS_PDOWN && powered_down_o && !rx_pu_o)
    else $error("power-down write did not stop the sequence");

  a_cal_never: assert property (
    state_r == SRS_RX_ON && cal_pol_w == CAL_NEVER |=> state_r != SRS_CAL)
    else $error("calibration run under the never policy");

endmodule
`default_nettype wire

//--- pkg/srs_pkg.sv
// Notes on behaviour
// - Eight active-low reset bits in one register, one per digital sub-block.
// - Bit three resets modulator, bit synchronizer and pseudo-random generator together.
// - Each reset bit returns to one by itself once its reset starts.
// - A sub-block reset only completes while that sub-block's clock runs.
// - With chip-select start enabled, each chip-select falling edge starts a sequence.
// - Otherwise data pin falling edges start it, only in split data mode.
// - Three-bit code sets PLL-lock to receiver power-up delay; code seven none.
// - Four-bit code sets carrier-sense wait in filter clock periods.
// - Sequencing register resets to start enabled, delay code zero, wait code ten.
// - Frequency word A high byte register at offset four, default 131.
// - Automatic sequencing only when power-down mode field equals three.
// - Automatic sequencing only in receive direction; never for transmit.
// - Writing a rising edge to sequence power-down forces power down.
// - Calibration at sequence end: never, always, every 16th or 256th.
package srs_pkg;

  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W = 7;
  localparam int unsigned NUM_SUB = 8;
  localparam int unsigned WAIT_W = 9;

  // ---------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_MAIN = 7'h00;
  localparam logic [IDX_W-1:0] IDX_IFACE = 7'h01;
  localparam logic [IDX_W-1:0] IDX_RESET = 7'h02;
  localparam logic [IDX_W-1:0] IDX_SEQ = 7'h03;
  localparam logic [IDX_W-1:0] IDX_FREQ2A = 7'h04;
  localparam logic [IDX_W-1:0] IDX_RST_DONE = 7'h41;
  localparam logic [IDX_W-1:0] IDX_STATE = 7'h42;
  localparam logic [IDX_W-1:0] IDX_SEQ_CNT = 7'h43;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] MAIN_RST = 8'h00;
  localparam logic [7:0] IFACE_RST = 8'h00;
  localparam logic [7:0] RESET_CTRL_RST = 8'h00;
  localparam logic [7:0] SEQ_CFG_RST = 8'h8a;
  localparam logic [7:0] FREQ2A_RST = 8'h83;

  localparam int unsigned MAIN_DIR_BIT = 7;
  localparam int unsigned MAIN_PDM_LSB = 4;
  localparam int unsigned MAIN_CAL_LSB = 2;
  localparam int unsigned MAIN_SPD_BIT = 1;
  localparam int unsigned IFACE_SPLIT_BIT = 6;
  localparam int unsigned CHIPSEL_START_ENABLE_BIT = 7;
  localparam int unsigned SEQ_RXW_LSB = 4;
  localparam int unsigned SEQ_CSW_LSB = 0;
  localparam int unsigned SUB_SEQ_IDX = 1;
  localparam int unsigned SUB_MODEM_IDX = 3;

  localparam logic [1:0] PDM_SEQUENCED = 2'h3;
  localparam logic [1:0] CAL_NEVER = 2'h0;
  localparam logic [1:0] CAL_ALWAYS = 2'h1;
  localparam logic [1:0] CAL_EVERY16 = 2'h2;
  localparam logic [1:0] CAL_EVERY256 = 2'h3;

  // ---------------------------------------------------------------
  // Timing counts
  // ---------------------------------------------------------------
  localparam int unsigned SUBRST_CYCLES = 4;

  localparam logic [WAIT_W-1:0] RX_WAIT_TAB [0:7] = '{
    9'h020, 9'h02c, 9'h040, 9'h058, 9'h080, 9'h0b0, 9'h100, 9'h000};

  localparam logic [WAIT_W-1:0] CS_WAIT_TAB [0:15] = '{
    9'h014, 9'h016, 9'h018, 9'h01a, 9'h01c, 9'h01e, 9'h020, 9'h024,
    9'h028, 9'h02c, 9'h034, 9'h034, 9'h038, 9'h03c, 9'h040, 9'h048};

  typedef enum logic [2:0] {
    SRS_PDOWN, SRS_SYNTH_UP, SRS_RX_DELAY, SRS_RX_ON, SRS_RX_ACTIVE, SRS_CAL
  } srs_state_t;

endpackage

//--- design/srs_subrst.sv
`timescale 1ns/1ps
`default_nettype none
module srs_subrst #(
  parameter int unsigned HOLD_CYCLES = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic clk_run_i,
  output logic rst_n_o,
  output logic done_o
);

  localparam int unsigned CNT_W = $clog2(HOLD_CYCLES + 1);

  logic pending_r;
  logic pending_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic last_w;

  // Counting only advances on cycles where the sub-block clock runs
  assign last_w = (cnt_r == CNT_W'(HOLD_CYCLES - 1));
  assign pending_nxt = start_i | (pending_r & ~(clk_run_i & last_w));
  assign cnt_nxt = start_i ? '0 :
                   (pending_r & clk_run_i) ? cnt_r + 1'b1 : cnt_r;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pending_r <= 1'b1;
      cnt_r <= '0;
      rst_n_o <= 1'b0;
    end else begin
      pending_r <= pending_nxt;
      cnt_r <= cnt_nxt;
      rst_n_o <= ~pending_nxt;
    end
  end

  assign done_o = ~pending_r;

  a_start_asserts: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    start_i |=> !rst_n_o && !done_o)
    else $error("sub-block reset not applied after start");

  a_hold_no_clk: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pending_r && !clk_run_i |=> pending_r)
    else $error("sub-block reset finished without its clock");

endmodule
`default_nettype wire

//--- tb/srs_radio_model.sv
`timescale 1ns/1ps
`default_nettype none
module srs_radio_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic synth_pu_i,
  input wire logic rx_pu_i,
  input wire logic pll_cal_i,
  input wire logic carrier_en_i,
  input wire logic [7:0] lock_dly_i,
  output logic adc_clk_o,
  output logic filter_clk_o,
  output logic pll_lock_o,
  output logic carrier_sense_o,
  output logic pll_cal_done_o
);
  // ---------------------------------------------------------------
  // Analog side: clocks at a quarter of the system rate, lock and
  // calibration answer after a delay; lock drops with the synthesizer
  // ---------------------------------------------------------------
  logic [1:0] div_r;
  logic [7:0] lock_cnt_r;
  logic [2:0] cal_cnt_r;

  assign adc_clk_o = div_r[1];
  assign filter_clk_o = div_r[1];
  assign pll_lock_o = synth_pu_i && (lock_cnt_r >= lock_dly_i);
  assign carrier_sense_o = rx_pu_i && carrier_en_i;
  assign pll_cal_done_o = pll_cal_i && (cal_cnt_r == 3'h5);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r <= 2'h0;
      lock_cnt_r <= 8'h00;
      cal_cnt_r <= 3'h0;
    end else begin
      div_r <= div_r + 2'h1;
      lock_cnt_r <= !synth_pu_i ? 8'h00 : (pll_lock_o ? lock_cnt_r : lock_cnt_r + 8'h01);
      cal_cnt_r <= !pll_cal_i ? 3'h0 : (pll_cal_done_o ? cal_cnt_r : cal_cnt_r + 3'h1);
    end
  end
endmodule
`default_nettype wire

//--- tb/srs_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module srs_sequencer_tb;
  import srs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic rd = 1'b0, wr = 1'b0, psel = 1'b1, data_io_pin = 1'b1, carrier_en = 1'b0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [3:0] be = 4'hf;
  logic [NUM_SUB-1:0] clk_run = '1, rst_n;
  logic waitreq, adc_clk, filt_clk, lock, cs, cal_done, synth_pu, rx_pu, cal, pdown, cal_d;
  logic [7:0] freq, q, low_seen = 8'h00, lock_dly = 8'h02;
  int miscompares = 0, cmp_count = 0, cyc = 0, cal_cnt = 0;
  int rx_tab [0:7] = '{32, 44, 64, 88, 128, 176, 256, 0};
  int cs_tab [0:15] = '{20, 22, 24, 26, 28, 30, 32, 36, 40, 44, 52, 52, 56, 60, 64, 72};

  srs_sequencer srs_sequencer_i (.sys_clk_i(clk), .rst_i(rst), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .psel_i(psel),
    .data_io_pin_i(data_io_pin), .adc_clk_i(adc_clk), .filter_clk_i(filt_clk),
    .subblock_clk_run_i(clk_run), .pll_lock_i(lock), .carrier_sense_i(cs),
    .pll_cal_done_i(cal_done), .subblock_rst_n_o(rst_n), .synth_pu_o(synth_pu),
    .rx_pu_o(rx_pu), .pll_cal_o(cal), .powered_down_o(pdown), .freq_word_set_a_o(freq));

  srs_radio_model srs_radio_model_i (.sys_clk_i(clk), .rst_i(rst), .synth_pu_i(synth_pu),
    .rx_pu_i(rx_pu), .pll_cal_i(cal), .carrier_en_i(carrier_en), .lock_dly_i(lock_dly),
    .adc_clk_o(adc_clk), .filter_clk_o(filt_clk), .pll_lock_o(lock),
    .carrier_sense_o(cs), .pll_cal_done_o(cal_done));

  always #12.5 clk = ~clk;

  // ---------------------------------------------------------------
  // Monitors sample on the falling edge, away from design updates
  // ---------------------------------------------------------------
  always @(negedge clk) begin
    low_seen <= low_seen | ~rst_n;
    cal_d <= cal;
    if (cal === 1'b1 && cal_d === 1'b0) cal_cnt++;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (miscompares == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rng(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // Request held until waitrequest is seen low; released after that edge
  task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h000000, d};
    // Read before this edge's updates land, so waitreq is what the edge saw
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50) rng(n, 0, 49);
  endtask

  task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask

  task automatic trig(input logic use_dio);
    @(posedge clk);
    if (use_dio) data_io_pin <= 1'b0;
    else psel <= 1'b0;
    @(posedge clk);
    data_io_pin <= 1'b1;
    psel <= 1'b1;
  endtask

  // Counts in system cycles; the model's clocks run at a quarter rate
  task automatic run_seq(input int rx_n, input int cs_n);
    int n, m;
    n = 0;
    m = 0;
    while (lock !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, synth_pu}, 8'h01);
    n = 0;
    while (rx_pu !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    rng(n, 4 * rx_n - 3, 4 * rx_n + 7);
    while (rx_pu === 1'b1 && m < 2000) begin
      @(negedge clk);
      m++;
    end
    rng(m, 4 * cs_n - 3, 4 * cs_n + 7);
    n = 0;
    while (pdown !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk({5'h00, synth_pu, rx_pu, pdown}, 8'h01);
  endtask

  task automatic nostart();
    trig(1'b0);
    trig(1'b1);
    repeat (10) @(posedge clk);
    chk({6'h00, synth_pu, pdown}, 8'h01);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk(9'h00c, 8'h8a);
    rd_chk(9'h010, 8'h83);
    rd_chk(9'h000, 8'h00);
    bus(1'b1, 9'h1fc, 8'h55);
    rd_chk(9'h1fc, 8'h00);
    bus(1'b1, 9'h010, 8'h5a);
    rd_chk(9'h010, 8'h5a);
    chk(freq, 8'h5a);
    // Per-block resets are exercised only here, never amid traffic
    for (int i = 0; i < 8; i++) begin
      low_seen = 8'h00;
      clk_run <= ~(8'h01 << i);
      bus(1'b1, 9'h008, ~(8'h01 << i));
      repeat (20) @(posedge clk);
      rd_chk(9'h104, ~(8'h01 << i));
      rd_chk(9'h008, 8'hff);
      clk_run <= 8'hff;
      q = 8'h00;
      for (int k = 0; k < 20 && q !== 8'hff; k++) bus(1'b0, 9'h104, 8'h00);
      chk(q, 8'hff);
      chk(low_seen, 8'h01 << i);
    end
    bus(1'b1, 9'h000, 8'h38);
    for (int i = 0; i < 16; i++) begin
      lock_dly <= i[0] ? 8'h28 : 8'h02;
      bus(1'b1, 9'h004, i[0] ? 8'h40 : 8'h00);
      bus(1'b1, 9'h00c, {~i[0], i[2:0], i[3:0]});
      trig(i[0]);
      run_seq(rx_tab[i % 8], cs_tab[i]);
    end
    chk(cal_cnt[7:0], 8'h01);
    rd_chk(9'h10c, 8'h10);
    bus(1'b1, 9'h00c, 8'h0a);
    bus(1'b1, 9'h004, 8'h00);
    nostart();
    bus(1'b1, 9'h00c, 8'h8a);
    bus(1'b1, 9'h000, 8'h20);
    nostart();
    bus(1'b1, 9'h000, 8'hb0);
    nostart();
    bus(1'b1, 9'h000, 8'h30);
    trig(1'b0);
    run_seq(rx_tab[0], cs_tab[10]);
    chk(cal_cnt[7:0], 8'h01);
    bus(1'b1, 9'h000, 8'h34);
    trig(1'b0);
    run_seq(rx_tab[0], cs_tab[10]);
    chk(cal_cnt[7:0], 8'h02);
    carrier_en <= 1'b1;
    trig(1'b0);
    for (int k = 0; k < 2000 && rx_pu !== 1'b1; k++) @(negedge clk);
    repeat (400) @(posedge clk);
    chk({7'h00, rx_pu}, 8'h01);
    rd_chk(9'h108, 8'h04);
    bus(1'b1, 9'h000, 8'h36);
    repeat (4) @(posedge clk);
    chk({5'h00, synth_pu, rx_pu, pdown}, 8'h01);
    complete_run();
  end
endmodule
`default_nettype wire
